// ### rtl/asdec_pkg.sv
// Purpose : Shared constants and types for the slice decode error/control block
// Assumes : Single 20 MHz clock, MMIO word addresses as byte offsets
// Notes   : Every offset, error bit position, reset value and count lives here once
package asdec_pkg;

  // MMIO register byte offsets
  localparam logic [15:0] ASDEC_OFS_ERR_FLAGS = 16'h4400;  // Error flag register
  localparam logic [15:0] ASDEC_OFS_ERR_COUNT = 16'h4404;  // Error count register
  localparam logic [15:0] ASDEC_OFS_RESET     = 16'h4408;  // Global reset trigger
  localparam logic [15:0] ASDEC_OFS_STATUS    = 16'h440c;  // Engine status, read only

  // Error flag bit positions
  localparam int ASDEC_BIT_SLICE_ERR = 0;  // General slice decoder error
  localparam int ASDEC_BIT_VLD_ERR   = 1;  // Variable length decode error
  localparam int ASDEC_BIT_PRED_ERR  = 2;  // Prediction reconstruction error
  localparam int ASDEC_BIT_EARLY_ERR = 3;  // Early finish error
  localparam int ASDEC_NUM_ERR       = 4;  // Number of error kinds

  // Field widths and reset values
  localparam int          ASDEC_CNT_W       = 12;      // Error counter width
  localparam logic [3:0]  ASDEC_FLAGS_RST   = 4'h0;    // Flags after reset
  localparam logic [11:0] ASDEC_COUNT_RST   = 12'h000; // Count after reset
  localparam logic [11:0] ASDEC_COUNT_MAX   = 12'hfff; // Saturation value
  localparam int          ASDEC_RST_BIT     = 0;       // Reset register trigger bit

  // Raw sample macroblock settings
  localparam int          ASDEC_MEM_BITS    = 512;     // Bits per memory access
  localparam int          ASDEC_RAW_BYTES   = 384;     // Bytes per raw macroblock
  localparam logic [7:0]  ASDEC_RAW_LUMA_CBP   = 8'hff;  // Every luma block present
  localparam logic [3:0]  ASDEC_RAW_CHROMA_CBP = 4'hf;   // Chroma present, colour
  localparam logic [3:0]  ASDEC_MONO_CHROMA_CBP = 4'h0;  // Chroma absent, monochrome
  localparam logic [2:0]  ASDEC_RAW_BEATS =
    3'((ASDEC_RAW_BYTES * 8 + ASDEC_MEM_BITS - 1) / ASDEC_MEM_BITS);

  // Timing: hold of the pipeline reset pulse
  localparam int          ASDEC_CLK_MHZ     = 20;      // Clock rate
  localparam int          ASDEC_RST_HOLD_NS = 200;     // Least reset pulse width
  localparam logic [3:0]  ASDEC_RST_CYCLES  =
    4'((ASDEC_RST_HOLD_NS * ASDEC_CLK_MHZ + 999) / 1000);

  // Emulation prevention
  localparam logic [7:0]  ASDEC_EPB_BYTE    = 8'h03;   // Inserted escape byte
  localparam logic [1:0]  ASDEC_EPB_ZEROS   = 2'd2;    // Zero bytes before escape

  // Command streamer states, one-hot
  typedef enum logic [4:0] {
    ASDEC_ST_IDLE   = 5'b00001,
    ASDEC_ST_DECODE = 5'b00010,
    ASDEC_ST_SFLUSH = 5'b00100,
    ASDEC_ST_PFLUSH = 5'b01000,
    ASDEC_ST_STORE  = 5'b10000
  } asdec_state_t;

endpackage

// ### rtl/asdec_epb_filter.sv
// Purpose : Slice payload fetcher byte path with escape byte removal
// Assumes : One byte per valid cycle, slice start/end are single pulses
// Notes   : Output is registered, one cycle behind the input byte
`timescale 1ns/1ps
module asdec_epb_filter
  import asdec_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_flush,        // Synchronous pipeline reset
  // Incoming payload
  input  wire logic       i_slice_start,
  input  wire logic       i_slice_end,
  input  wire logic [7:0] i_byte,
  input  wire logic       i_byte_valid,
  // Cleaned payload to the entropy decode unit
  output logic      [7:0] o_byte,
  output logic            o_byte_valid,
  output logic            o_in_slice
);

  typedef struct packed {
    logic       in_slice;   // Between slice start and end
    logic [1:0] zero_run;   // Zero bytes just seen, saturating
    logic [7:0] data;       // Output byte
    logic       valid;      // Output strobe
  } asdec_epb_t;

  asdec_epb_t s_reg;        // Registered state
  asdec_epb_t s_next;       // Next state

  ////////////////////////////////////////////////////////////////////////////
  // Next state: track slice bounds and drop escape bytes
  always_comb begin
    s_next       = s_reg;
    s_next.valid = 1'b0;
    if (i_flush) begin
      s_next = '0;
    end else begin
      if (i_slice_start) begin                       // Slice start detect
        s_next.in_slice = 1'b1;
        s_next.zero_run = 2'd0;
      end
      if (i_byte_valid && (s_reg.in_slice || i_slice_start)) begin
        if (s_reg.zero_run >= ASDEC_EPB_ZEROS && i_byte == ASDEC_EPB_BYTE) begin
          s_next.zero_run = 2'd0;                    // Escape dropped
        end else begin
          s_next.data  = i_byte;
          s_next.valid = 1'b1;
          if (i_byte == 8'h00) begin
            s_next.zero_run = (s_reg.zero_run == 2'd3) ? 2'd3 : s_reg.zero_run + 2'd1;
          end else begin
            s_next.zero_run = 2'd0;
          end
        end
      end
      if (i_slice_end) begin                         // Slice end detect
        s_next.in_slice = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_byte       = s_reg.data;
  assign o_byte_valid = s_reg.valid;
  assign o_in_slice   = s_reg.in_slice;

endmodule // asdec_epb_filter

// ### rtl/asdec_err_ctrl.sv
// Purpose : Error status, global reset and flush control of the slice decoder
// Assumes : MMIO strobes and decoder events are synchronous single-cycle pulses
// Notes   : Reads answer one cycle after the read strobe with o_mmio_rvalid
//
// What this block does
// - Error flag register at 4400h, upper bits zero
// - Bit 3 latches enabled early finish errors
// - Bit 2 latches enabled prediction reconstruction errors
// - Bit 1 latches enabled variable length errors
// - Bit 0 latches enabled general decoder errors
// - Writes only clear flags, never set them
// - Error count register at 4404h, 12-bit count
// - Count increments on any recognised error
// - Counter saturates at maximum, never wraps
// - Any count write zeroes; both zero after reset
// - Recorded errors raise a host interrupt
// - MMIO global reset clears pipeline immediately
// - Implicit flush after every slice decode
// - Picture flush waits unit dones, then store
// - Slice decode and buffers pre-empted only by global reset
// - Memory accesses are 512 bits wide
// - Fetcher finds slice bounds, strips escape bytes
// - Raw macroblock is exactly 384 bytes
// - Raw macroblock: luma pattern ones, DC flags zero
// - Raw chroma patterns 0xF colour, 0x0 monochrome
`timescale 1ns/1ps
module asdec_err_ctrl
  import asdec_pkg::*;
(
  // Clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  // MMIO register port
  input  wire logic                     i_mmio_wr,
  input  wire logic                     i_mmio_rd,
  input  wire logic [15:0]              i_mmio_addr,
  input  wire logic [31:0]              i_mmio_wdata,
  output logic      [31:0]              o_mmio_rdata,
  output logic                          o_mmio_rvalid,
  // Decoder error events and per-object handling enables
  input  wire logic [ASDEC_NUM_ERR-1:0] i_err_event,
  input  wire logic [ASDEC_NUM_ERR-1:0] i_err_handle_en,
  output logic                          o_err_irq,
  // Command streamer side
  input  wire logic                     i_obj_valid,
  output logic                          o_obj_ready,
  input  wire logic                     i_slice_done,
  input  wire logic                     i_pic_flush,
  output logic                          o_pic_flush_ready,
  output logic                          o_slice_complete,
  output logic                          o_store_dword,
  output logic                          o_pipe_rst,
  // Unit done indications
  input  wire logic                     i_fetch_done,
  input  wire logic                     i_entropy_done,
  input  wire logic                     i_mem_done,
  // Payload bytes to the slice payload fetcher
  input  wire logic                     i_slice_start,
  input  wire logic                     i_slice_end,
  input  wire logic [7:0]               i_payload_byte,
  input  wire logic                     i_payload_valid,
  output logic      [7:0]               o_payload_byte,
  output logic                          o_payload_valid,
  output logic                          o_in_slice,
  // Raw sample macroblock parameters
  input  wire logic                     i_raw_mb,
  input  wire logic                     i_monochrome,
  output logic      [7:0]               o_luma_block_pattern,
  output logic      [3:0]               o_red_chroma_block_pattern,
  output logic      [3:0]               o_blue_chroma_block_pattern,
  output logic                          o_luma_dc_present_flag,
  output logic                          o_blue_dc_present_flag,
  output logic                          o_red_dc_present_flag,
  output logic                          o_mb_skipped,
  output logic      [2:0]               o_raw_mem_beats,
  output logic                          o_raw_params_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // State of the block, one packed struct

  typedef struct packed {
    logic [ASDEC_NUM_ERR-1:0] flags;       // Sticky error flags
    logic [ASDEC_CNT_W-1:0]   count;       // Saturating error counter
    asdec_state_t             st;          // Command streamer state
    logic [3:0]               rst_cnt;     // Remaining pipeline reset cycles
    logic                     pipe_rst;    // Pipeline reset out
    logic                     irq;         // Interrupt out
    logic [31:0]              rdata;       // Read data
    logic                     rvalid;      // Read answer strobe
    logic                     obj_ready;   // Object command accepted
    logic                     pflush_rdy;  // Picture flush accepted
    logic                     slice_cmpl;  // Slice done and flushed
    logic                     store;       // Store dword pulse
    logic [7:0]               cbp_y;       // Luma block pattern
    logic [3:0]               cbp_cr;      // Red chroma block pattern
    logic [3:0]               cbp_cb;      // Blue chroma block pattern
    logic                     dc_y;        // Luma DC present
    logic                     dc_cb;       // Blue DC present
    logic                     dc_cr;       // Red DC present
    logic                     skipped;     // Macroblock skipped
    logic [2:0]               raw_beats;   // Memory beats per raw macroblock
    logic                     raw_valid;   // Raw parameters strobe
  } asdec_ctrl_t;

  asdec_ctrl_t s_reg;                      // Registered state
  asdec_ctrl_t s_next;                     // Next state

  logic [ASDEC_NUM_ERR-1:0] flag_set;      // Enabled errors this cycle
  logic                     any_err;       // Any recognised error
  logic                     wr_flags;      // Write to flag register
  logic                     wr_count;      // Write to count register
  logic                     wr_reset;      // Global reset request
  logic                     units_done;    // All units report done
  logic                     pipe_flush;    // Sync clear to the fetcher

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  always_comb begin
    wr_flags = 1'b0;
    wr_count = 1'b0;
    wr_reset = 1'b0;
    if (i_mmio_wr && i_mmio_addr == ASDEC_OFS_ERR_FLAGS) begin
      wr_flags = 1'b1;
    end else if (i_mmio_wr && i_mmio_addr == ASDEC_OFS_ERR_COUNT) begin
      wr_count = 1'b1;
    end else if (i_mmio_wr && i_mmio_addr == ASDEC_OFS_RESET) begin
      wr_reset = i_mmio_wdata[ASDEC_RST_BIT];
    end
  end

  // Error qualification: flags need the enable, the counter does not
  assign flag_set   = i_err_event & i_err_handle_en;
  assign any_err    = |i_err_event;
  assign units_done = i_fetch_done & i_entropy_done & i_mem_done;
  // Fetcher is cleared while the pipeline reset pulse runs
  assign pipe_flush = s_reg.pipe_rst;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    s_next            = s_reg;
    s_next.rvalid     = 1'b0;
    s_next.obj_ready  = 1'b0;
    s_next.pflush_rdy = 1'b0;
    s_next.slice_cmpl = 1'b0;
    s_next.store      = 1'b0;
    s_next.raw_valid  = 1'b0;

    // Flags: write-one clears, then events set so a set wins over a clear
    if (wr_flags) begin
      s_next.flags = s_reg.flags & ~i_mmio_wdata[ASDEC_NUM_ERR-1:0];
    end
    s_next.flags[ASDEC_BIT_EARLY_ERR] = s_next.flags[ASDEC_BIT_EARLY_ERR]
                                      | flag_set[ASDEC_BIT_EARLY_ERR];
    s_next.flags[ASDEC_BIT_PRED_ERR]  = s_next.flags[ASDEC_BIT_PRED_ERR]
                                      | flag_set[ASDEC_BIT_PRED_ERR];
    s_next.flags[ASDEC_BIT_VLD_ERR]   = s_next.flags[ASDEC_BIT_VLD_ERR]
                                      | flag_set[ASDEC_BIT_VLD_ERR];
    s_next.flags[ASDEC_BIT_SLICE_ERR] = s_next.flags[ASDEC_BIT_SLICE_ERR]
                                      | flag_set[ASDEC_BIT_SLICE_ERR];

    // Counter: any write zeroes it; an error in the same cycle still counts
    if (wr_count) begin
      s_next.count = any_err ? ASDEC_CNT_W'(1) : ASDEC_COUNT_RST;
    end else if (any_err && s_reg.count != ASDEC_COUNT_MAX) begin
      s_next.count = s_reg.count + ASDEC_CNT_W'(1);
    end
    // Held at maximum otherwise, no wrap

    // Interrupt is level: high while any flag stays recorded
    s_next.irq = |s_next.flags;

    // Read path, reserved bits zero, unmapped offsets read zero
    if (i_mmio_rd) begin
      s_next.rvalid = 1'b1;
      if (i_mmio_addr == ASDEC_OFS_ERR_FLAGS) begin
        s_next.rdata = {28'h0000000, s_reg.flags};
      end else if (i_mmio_addr == ASDEC_OFS_ERR_COUNT) begin
        s_next.rdata = {20'h00000, s_reg.count};
      end else if (i_mmio_addr == ASDEC_OFS_STATUS) begin
        s_next.rdata = {26'h0, s_reg.pipe_rst, s_reg.st};
      end else begin
        s_next.rdata = 32'h00000000;
      end
    end

    // Pipeline reset countdown
    if (s_reg.rst_cnt != 4'h0) begin
      s_next.rst_cnt = s_reg.rst_cnt - 4'h1;
    end
    s_next.pipe_rst = (s_next.rst_cnt != 4'h0);

    // Command streamer sequencing; a started slice runs to the end or to a global reset
    case (s_reg.st)
      ASDEC_ST_IDLE: begin
        if (i_obj_valid) begin
          s_next.obj_ready = 1'b1;
          s_next.st        = ASDEC_ST_DECODE;
        end else if (i_pic_flush) begin
          s_next.pflush_rdy = 1'b1;
          s_next.st         = ASDEC_ST_PFLUSH;
        end
      end
      ASDEC_ST_DECODE: begin
        // No new object or flush taken until the slice is finished
        if (i_slice_done) begin
          s_next.st = ASDEC_ST_SFLUSH;
        end
      end
      ASDEC_ST_SFLUSH: begin
        // Streamer halts until the units have drained
        if (units_done) begin
          s_next.slice_cmpl = 1'b1;
          s_next.st         = ASDEC_ST_IDLE;
        end
      end
      ASDEC_ST_PFLUSH: begin
        if (units_done) begin
          s_next.st = ASDEC_ST_STORE;
        end
      end
      ASDEC_ST_STORE: begin
        s_next.store = 1'b1;
        s_next.st    = ASDEC_ST_IDLE;
      end
      default: begin
        s_next.st = ASDEC_ST_IDLE;
      end
    endcase

    // Raw sample macroblock parameter settings
    if (i_raw_mb) begin
      s_next.raw_valid = 1'b1;
      s_next.skipped   = 1'b0;
      s_next.cbp_y     = ASDEC_RAW_LUMA_CBP;
      s_next.dc_y      = 1'b0;
      s_next.dc_cb     = 1'b0;
      s_next.dc_cr     = 1'b0;
      s_next.cbp_cr    = i_monochrome ? ASDEC_MONO_CHROMA_CBP
                                      : ASDEC_RAW_CHROMA_CBP;
      s_next.cbp_cb    = i_monochrome ? ASDEC_MONO_CHROMA_CBP
                                      : ASDEC_RAW_CHROMA_CBP;
      // 384 bytes move as whole 512-bit memory beats
      s_next.raw_beats = ASDEC_RAW_BEATS;
    end

    // Global reset overrides any operation in progress; error registers
    // survive so software can still read why it had to reset.
    if (wr_reset) begin
      s_next.st         = ASDEC_ST_IDLE;
      s_next.rst_cnt    = ASDEC_RST_CYCLES;
      s_next.pipe_rst   = 1'b1;
      s_next.obj_ready  = 1'b0;
      s_next.pflush_rdy = 1'b0;
      s_next.slice_cmpl = 1'b0;
      s_next.store      = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; power-up clears both error registers

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg       <= '0;
      s_reg.flags <= ASDEC_FLAGS_RST;
      s_reg.count <= ASDEC_COUNT_RST;
      s_reg.st    <= ASDEC_ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slice payload fetcher byte path

  asdec_epb_filter u_fetch (
    .i_clk         (i_clk),
    .i_rst_n       (i_rst_n),
    .i_flush       (pipe_flush),
    .i_slice_start (i_slice_start),
    .i_slice_end   (i_slice_end),
    .i_byte        (i_payload_byte),
    .i_byte_valid  (i_payload_valid),
    .o_byte        (o_payload_byte),
    .o_byte_valid  (o_payload_valid),
    .o_in_slice    (o_in_slice)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs other than the payload path, all from the state register

  assign o_mmio_rdata                = s_reg.rdata;
  assign o_mmio_rvalid               = s_reg.rvalid;
  assign o_err_irq                   = s_reg.irq;
  assign o_obj_ready                 = s_reg.obj_ready;
  assign o_pic_flush_ready           = s_reg.pflush_rdy;
  assign o_slice_complete            = s_reg.slice_cmpl;
  assign o_store_dword               = s_reg.store;
  assign o_pipe_rst                  = s_reg.pipe_rst;
  assign o_luma_block_pattern        = s_reg.cbp_y;
  assign o_red_chroma_block_pattern  = s_reg.cbp_cr;
  assign o_blue_chroma_block_pattern = s_reg.cbp_cb;
  assign o_luma_dc_present_flag      = s_reg.dc_y;
  assign o_blue_dc_present_flag      = s_reg.dc_cb;
  assign o_red_dc_present_flag       = s_reg.dc_cr;
  assign o_mb_skipped                = s_reg.skipped;
  assign o_raw_mem_beats             = s_reg.raw_beats;
  assign o_raw_params_valid          = s_reg.raw_valid;

endmodule // asdec_err_ctrl

// ### sim/asdec_err_ctrl_props.sv
// Purpose: Port assertions for the error control block
// Assumes: One clock, asynchronous active-low reset
// Notes  : Bound onto every asdec_err_ctrl instance
`timescale 1ns/1ps
module asdec_err_ctrl_props
  import asdec_pkg::*;
(
  // Clock, reset and register port
  input wire logic                     i_clk,
  input wire logic                     i_rst_n,
  input wire logic                     i_mmio_wr,
  input wire logic                     i_mmio_rd,
  input wire logic [15:0]              i_mmio_addr,
  input wire logic [31:0]              i_mmio_wdata,
  input wire logic [31:0]              o_mmio_rdata,
  input wire logic                     o_mmio_rvalid,
  // Errors, streamer and raw settings
  input wire logic [ASDEC_NUM_ERR-1:0] i_err_event,
  input wire logic [ASDEC_NUM_ERR-1:0] i_err_handle_en,
  input wire logic                     o_err_irq,
  input wire logic                     o_slice_complete,
  input wire logic                     o_store_dword,
  input wire logic                     o_pipe_rst,
  input wire logic                     i_fetch_done,
  input wire logic                     i_entropy_done,
  input wire logic                     i_mem_done,
  input wire logic                     i_raw_mb,
  input wire logic [7:0]               o_luma_block_pattern,
  input wire logic [2:0]               o_raw_mem_beats,
  input wire logic                     o_raw_params_valid
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire all_done = i_fetch_done && i_entropy_done && i_mem_done;  // Every unit idle
  sequence s_rst_hold;
    o_pipe_rst [*4] ##1 !o_pipe_rst;
  endsequence
  sequence s_raw_fixed;
    o_raw_params_valid && o_luma_block_pattern == 8'hff && o_raw_mem_beats == 3'h6;
  endsequence
  chk_read_answer: assert property (i_mmio_rd |=> o_mmio_rvalid)
    else $error("read not answered");
  chk_flags_rsvd: assert property (i_mmio_rd && i_mmio_addr == ASDEC_OFS_ERR_FLAGS
    |=> o_mmio_rdata[31:4] == 28'h0) else $error("flag upper bits set");
  chk_count_rsvd: assert property (i_mmio_rd && i_mmio_addr == ASDEC_OFS_ERR_COUNT
    |=> o_mmio_rdata[31:12] == 20'h0) else $error("count upper bits set");
  chk_irq_on_err: assert property (|(i_err_event & i_err_handle_en) |=> o_err_irq)
    else $error("enabled error gave no interrupt");
  chk_write_noset: assert property (!o_err_irq && !(|(i_err_event & i_err_handle_en))
    |=> !o_err_irq) else $error("flag set without error");
  chk_slice_flush: assert property (o_slice_complete |-> $past(all_done))
    else $error("slice complete before units done");
  chk_store_order: assert property (o_store_dword |-> $past(all_done, 2))
    else $error("store issued before units done");
  chk_pipe_reset: assert property (i_mmio_wr && i_mmio_addr == ASDEC_OFS_RESET
    && i_mmio_wdata[0] |=> s_rst_hold) else $error("pipeline reset pulse wrong");
  chk_raw_params: assert property (i_raw_mb |=> s_raw_fixed)
    else $error("raw macroblock settings wrong");
endmodule // asdec_err_ctrl_props
bind asdec_err_ctrl asdec_err_ctrl_props props_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_mmio_wr(i_mmio_wr), .i_mmio_rd(i_mmio_rd), .i_mmio_addr(i_mmio_addr),
  .i_mmio_wdata(i_mmio_wdata), .o_mmio_rdata(o_mmio_rdata), .o_mmio_rvalid(o_mmio_rvalid),
  .i_err_event(i_err_event), .i_err_handle_en(i_err_handle_en), .o_err_irq(o_err_irq),
  .o_slice_complete(o_slice_complete), .o_store_dword(o_store_dword),
  .o_pipe_rst(o_pipe_rst), .i_fetch_done(i_fetch_done), .i_entropy_done(i_entropy_done),
  .i_mem_done(i_mem_done), .i_raw_mb(i_raw_mb), .o_luma_block_pattern(o_luma_block_pattern),
  .o_raw_mem_beats(o_raw_mem_beats), .o_raw_params_valid(o_raw_params_valid));

// ### sim/asdec_unit_model.sv
// Purpose: Fetch, entropy and memory units as seen by the streamer
// Assumes: i_kick pulses when an object or flush is taken
// Notes  : Lag per run lets the block see prompt and slow units
`timescale 1ns/1ps
module asdec_unit_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_kick,   // Work begins
  input  wire logic [3:0] i_lag,    // Cycles until done
  output logic            o_done    // All three units done
);
  logic [3:0] left_reg;  // Cycles left before done
  // Done drops on a kick and returns after the lag
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) left_reg <= 4'h0;
    else if (i_kick) left_reg <= i_lag;
    else if (left_reg != 4'h0) left_reg <= left_reg - 4'h1;
  end
  assign o_done = (left_reg == 4'h0);
endmodule // asdec_unit_model

// ### sim/asdec_err_ctrl_test.sv
// Purpose: Self-checking bench of the error control block
// Assumes: Inputs change 1 ns after the rising edge
// Notes  : Error rows in a table, awkward cases by hand
`timescale 1ns/1ps
module asdec_err_ctrl_test
  import asdec_pkg::*;
;
  logic        clk, rst_n, wr, rd, obj, sdone, pflush, sst, send, pv, raw, mono;
  logic [15:0] addr;
  logic [31:0] wdata, rdata;
  logic [7:0]  pb, ob, luma, q[$];
  logic [3:0]  ev, en, lag, cr, cb;
  logic [2:0]  beats;
  logic        rv, irq, objr, pfr, scpl, store, prst, ov, insl, dy, dcb, dcr, skp, rpv, done;
  int          num_errors, n_checks, i;
  // Rows: event, enable, expected flags, expected count
  localparam logic [15:0] ROWS [6] = '{16'h1111, 16'h2221, 16'h4441, 16'h8881,
                                      16'h1001, 16'hfff1};
  localparam logic [7:0] BYTES [4] = '{8'h00, 8'h00, 8'h03, 8'h01};
  asdec_err_ctrl dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_mmio_wr(wr), .i_mmio_rd(rd),
    .i_mmio_addr(addr), .i_mmio_wdata(wdata), .o_mmio_rdata(rdata), .o_mmio_rvalid(rv),
    .i_err_event(ev), .i_err_handle_en(en), .o_err_irq(irq), .i_obj_valid(obj),
    .o_obj_ready(objr), .i_slice_done(sdone), .i_pic_flush(pflush), .o_pic_flush_ready(pfr),
    .o_slice_complete(scpl), .o_store_dword(store), .o_pipe_rst(prst), .i_fetch_done(done),
    .i_entropy_done(done), .i_mem_done(done), .i_slice_start(sst), .i_slice_end(send),
    .i_payload_byte(pb), .i_payload_valid(pv), .o_payload_byte(ob), .o_payload_valid(ov),
    .o_in_slice(insl), .i_raw_mb(raw), .i_monochrome(mono), .o_luma_block_pattern(luma),
    .o_red_chroma_block_pattern(cr), .o_blue_chroma_block_pattern(cb),
    .o_luma_dc_present_flag(dy), .o_blue_dc_present_flag(dcb), .o_red_dc_present_flag(dcr),
    .o_mb_skipped(skp), .o_raw_mem_beats(beats), .o_raw_params_valid(rpv));
  asdec_unit_model model_u (.i_clk(clk), .i_rst_n(rst_n), .i_kick(objr | pflush), .i_lag(lag),
    .o_done(done));
  always #25 clk = ~clk;
  // Collect cleaned payload bytes
  always @(posedge clk) if (ov === 1'h1) q.push_back(ob);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // One register cycle; strobe dropped after its edge
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk) #1;
    {wr, rd, addr, wdata} = {w, !w, a, d};
    @(posedge clk) #1;
    {wr, rd} = 2'h0;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [31:0] e);
    acc(1'h0, a, 32'h0);
    chk(rv, 32'h1);
    chk(rdata, e);
  endtask
  task automatic pulse_err(input logic [3:0] e);
    @(posedge clk) #1;
    ev = e;
    @(posedge clk) #1;
    ev = 4'h0;
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Far beyond the roughly 4250-cycle run: a hang
  initial begin
    #2_000_000;
    num_errors++;
    results();
  end
  initial begin
    {clk, rst_n, wr, rd, obj, sdone, pflush, sst, send, pv, raw, mono} = 12'h0;
    {addr, wdata, pb, ev, en} = 64'h0;
    lag = 4'h3;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'h1;
    rdc(ASDEC_OFS_ERR_FLAGS, 32'h0);
    rdc(ASDEC_OFS_ERR_COUNT, 32'h0);
    rdc(16'h4410, 32'h0);
    foreach (ROWS[r]) begin
      acc(1'h1, ASDEC_OFS_ERR_FLAGS, 32'hf);
      acc(1'h1, ASDEC_OFS_ERR_COUNT, 32'h0);
      en = ROWS[r][11:8];
      pulse_err(ROWS[r][15:12]);
      rdc(ASDEC_OFS_ERR_FLAGS, {28'h0, ROWS[r][7:4]});
      rdc(ASDEC_OFS_ERR_COUNT, {28'h0, ROWS[r][3:0]});
    end
    acc(1'h1, ASDEC_OFS_ERR_FLAGS, 32'hfffffff4);
    rdc(ASDEC_OFS_ERR_FLAGS, 32'hb);
    acc(1'h1, ASDEC_OFS_ERR_FLAGS, 32'h0);
    rdc(ASDEC_OFS_ERR_FLAGS, 32'hb);
    chk(irq, 32'h1);
    acc(1'h1, ASDEC_OFS_ERR_FLAGS, 32'hb);
    chk(irq, 32'h0);
    en = 4'h0;
    @(posedge clk) #1;
    ev = 4'h1;
    repeat (4097) @(posedge clk);
    #1 ev = 4'h0;
    rdc(ASDEC_OFS_ERR_COUNT, 32'hfff);
    acc(1'h1, ASDEC_OFS_ERR_COUNT, 32'h5a);
    rdc(ASDEC_OFS_ERR_COUNT, 32'h0);
    // Prompt then slow units; one picture per command buffer
    for (int k = 0; k < 2; k++) begin
      lag = k ? 4'h9 : 4'h2;
      obj = 1'h1;
      for (i = 0; i < 20 && objr !== 1'h1; i++) @(posedge clk) #1;
      obj = 1'h0;
      sdone = 1'h1;
      @(posedge clk) #1 sdone = 1'h0;
      for (i = 0; i < 20 && scpl !== 1'h1; i++) @(posedge clk) #1;
      chk(scpl, 32'h1);
      pflush = 1'h1;
      for (i = 0; i < 20 && pfr !== 1'h1; i++) @(posedge clk) #1;
      pflush = 1'h0;
      for (i = 0; i < 20 && store !== 1'h1; i++) @(posedge clk) #1;
      chk(store, 32'h1);
    end
    acc(1'h1, ASDEC_OFS_RESET, 32'h1);
    chk(prst, 32'h1);
    rdc(ASDEC_OFS_STATUS, 32'h21);
    repeat (6) @(posedge clk);
    for (int m = 0; m < 2; m++) begin
      mono = m[0];
      @(posedge clk) #1 raw = 1'h1;
      @(posedge clk) #1 raw = 1'h0;
      chk({rpv, luma, dy, dcb, dcr, skp, beats}, {9'h1ff, 7'h6});
      chk({cr, cb}, m ? 8'h00 : 8'hff);
    end
    for (i = 0; i < 5; i++) begin
      @(posedge clk) #1;
      {pv, sst, send} = {1'h1, i == 0, i == 3};
      pb = (i < 4) ? BYTES[i] : 8'h55;
    end
    @(posedge clk) #1 {pv, send} = 2'h0;
    repeat (2) @(posedge clk);
    chk(q.size(), 32'h3);
    chk({insl, q[0], q[1], q[2]}, 32'h000001);
    results();
  end
endmodule // asdec_err_ctrl_test
